// File: include/sws_params.svh
`ifndef SWS_PARAMS_SVH
`define SWS_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------------
`define SWS_ADDR_W 8
`define SWS_OFF_SERVICE 8'h00
`define SWS_OFF_STATUS 8'h04

// ----------------------------------------------------------------------
// service register fields
// ----------------------------------------------------------------------
`define SWS_SEL_HI 7
`define SWS_SEL_LO 6
`define SWS_KEY_HI 5
`define SWS_KEY_LO 1
`define SWS_CM_BIT 0
`define SWS_KEY_VALUE 5'h0C
`define SWS_RST_WIN_SEL 2'h3
`define SWS_RST_CM_EN 1'b1

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define SWS_ST_PEND 0
`define SWS_ST_DRIVE 1
`define SWS_ST_LOCK 2
`define SWS_ST_CLKERR 3
`define SWS_ST_PIN 4

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define SWS_CLK_MHZ 20
`define SWS_TC_DIV 4
`define SWS_LOWER_TC 2048
`define SWS_UPPER_BASE_TC 8192
`define SWS_STRETCH_TC 20
`define SWS_IDLE_BIT 12
`define SWS_CKMON_TIME_US 1000
`define SWS_CKMON_CYC (`SWS_CKMON_TIME_US * `SWS_CLK_MHZ)

// ----------------------------------------------------------------------
// counter widths
// ----------------------------------------------------------------------
`define SWS_WIN_W 17
`define SWS_GAP_W 24
`define SWS_DIV_W 8
`define SWS_STR_W 6

`endif

// File: include/sws_pkg.sv
`include "sws_params.svh"

package sws_pkg;

  // ----------------------------------------------------------------------
  // supervision sequence states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SWS_RUN   = 4'b0001,
    SWS_DRIVE = 4'b0010,
    SWS_HOLD  = 4'b0100,
    SWS_WAIT  = 4'b1000
  } sws_state_t;

  // ----------------------------------------------------------------------
  // whole state of the supervisor
  // ----------------------------------------------------------------------
  typedef struct packed {
    sws_state_t state;
    logic lock;
    logic [1:0] win_sel;
    logic cm_en;
    logic lower_act;
    logic [`SWS_WIN_W-1:0] win_cnt;
    logic [`SWS_DIV_W-1:0] div_cnt;
    logic tc;
    logic [`SWS_STR_W-1:0] str_cnt;
    logic cm_drive;
    logic [`SWS_STR_W-1:0] cm_cnt;
    logic [`SWS_GAP_W-1:0] ck_gap;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    logic pin_s1;
    logic pin_s2;
    logic halt_d;
    logic idle_d;
    logic [`SWS_IDLE_BIT:0] idle_cnt;
    logic idle_pend;
    logic fault_oe;
    logic fault_n;
    logic awready;
    logic aw_have;
    logic [`SWS_ADDR_W-1:0] aw_addr;
    logic wready;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } sws_reg_t;

endpackage

// File: src/sws_supervisor.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sws_params.svh"

module sws_supervisor #(
  parameter int TC_DIV = `SWS_TC_DIV,
  parameter int LOWER_TC = `SWS_LOWER_TC,
  parameter int UPPER_BASE_TC = `SWS_UPPER_BASE_TC,
  parameter int STRETCH_TC = `SWS_STRETCH_TC,
  parameter int CKMON_CYC = `SWS_CKMON_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [`SWS_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [`SWS_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // processor power modes and oscillator options
  input wire logic halt_mode,
  input wire logic idle_mode,
  input wire logic rc_osc_sel,
  input wire logic startup_delay_sel,
  // monitored clock input pin
  input wire logic clock_input_pin,
  // open-drain fault pin
  input wire logic fault_pin,
  output logic fault_out_n,
  output logic fault_out_oe,
  // idle timer pending flag
  output logic idle_tick_pending
);
  import sws_pkg::*;

  // ----------------------------------------------------------------------
  // constants at the widths they meet
  // ----------------------------------------------------------------------
  localparam logic [`SWS_DIV_W-1:0] DIV_LAST = `SWS_DIV_W'(TC_DIV - 1);
  localparam logic [`SWS_WIN_W-1:0] LOWER_CNT = `SWS_WIN_W'(LOWER_TC);
  localparam logic [`SWS_STR_W-1:0] STR_LAST = `SWS_STR_W'(STRETCH_TC - 1);
  localparam logic [`SWS_GAP_W-1:0] GAP_LIMIT = `SWS_GAP_W'(CKMON_CYC);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  sws_reg_t st_r = '0;
  sws_reg_t st_nxt;

  logic ck_edge;
  logic ck_slow;
  logic halt_exit;
  logic idle_exit;
  logic susp;
  logic wr_fire;
  logic svc;
  logic key_ok;
  logic full_match;
  logic early;
  logic [`SWS_WIN_W:0] upper_ext;
  logic [`SWS_WIN_W-1:0] upper_last;
  logic [`SWS_IDLE_BIT:0] idle_inc;

  // ----------------------------------------------------------------------
  // decoded events of the current cycle
  // ----------------------------------------------------------------------
  assign ck_edge = st_r.ck_s2 ^ st_r.ck_s3;
  assign ck_slow = (st_r.ck_gap >= GAP_LIMIT);
  assign halt_exit = st_r.halt_d & ~halt_mode;
  assign idle_exit = st_r.idle_d & ~idle_mode;
  assign susp = halt_mode | idle_mode;
  assign wr_fire = st_r.aw_have & st_r.w_have & ~st_r.bvalid;
  assign svc = wr_fire & st_r.wstrb0 & (st_r.aw_addr == `SWS_OFF_SERVICE);
  assign key_ok = (st_r.wdata[`SWS_KEY_HI:`SWS_KEY_LO] == `SWS_KEY_VALUE);
  assign full_match = key_ok
    & (st_r.wdata[`SWS_SEL_HI:`SWS_SEL_LO] == st_r.win_sel)
    & (st_r.wdata[`SWS_CM_BIT] == st_r.cm_en);
  assign early = st_r.lower_act & (st_r.win_cnt < LOWER_CNT);
  // upper bound doubles with each step of the window select
  assign upper_ext = (`SWS_WIN_W+1)'(UPPER_BASE_TC) << st_r.win_sel;
  assign upper_last = `SWS_WIN_W'(upper_ext - 1'b1);
  assign idle_inc = st_r.idle_cnt + 1'b1;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // instruction-cycle enable from the divider
    st_nxt.tc = 1'b0;
    if (st_r.div_cnt == DIV_LAST)
    begin
      st_nxt.div_cnt = '0;
      st_nxt.tc = 1'b1;
    end
    else
    begin
      st_nxt.div_cnt = st_r.div_cnt + 1'b1;
    end

    // synchronisers for the two pins
    st_nxt.ck_s1 = clock_input_pin;
    st_nxt.ck_s2 = st_r.ck_s1;
    st_nxt.ck_s3 = st_r.ck_s2;
    st_nxt.pin_s1 = fault_pin;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.halt_d = halt_mode;
    st_nxt.idle_d = idle_mode;

    // gap since the last clock pin edge, saturating
    if (ck_edge)
    begin
      st_nxt.ck_gap = '0;
    end
    else if (!ck_slow)
    begin
      st_nxt.ck_gap = st_r.ck_gap + 1'b1;
    end

    // clock monitor, free of halt and idle
    if (!st_r.cm_en)
    begin
      st_nxt.cm_drive = 1'b0;
      st_nxt.cm_cnt = '0;
    end
    else if (ck_slow)
    begin
      st_nxt.cm_drive = 1'b1;
      st_nxt.cm_cnt = '0;
    end
    else if (st_r.cm_drive && st_r.tc)
    begin
      // stretched release after recovery
      if (st_r.cm_cnt == STR_LAST)
      begin
        st_nxt.cm_drive = 1'b0;
      end
      else
      begin
        st_nxt.cm_cnt = st_r.cm_cnt + 1'b1;
      end
    end

    // idle timer and its pending flag, set beats clear
    if (wr_fire && st_r.wstrb0 && (st_r.aw_addr == `SWS_OFF_STATUS)
        && st_r.wdata[`SWS_ST_PEND])
    begin
      st_nxt.idle_pend = 1'b0;
    end
    if (st_r.tc)
    begin
      st_nxt.idle_cnt = idle_inc;
      if (idle_inc[`SWS_IDLE_BIT] != st_r.idle_cnt[`SWS_IDLE_BIT])
      begin
        st_nxt.idle_pend = 1'b1;
      end
    end

    // supervision sequence
    case (st_r.state)
      SWS_RUN:
      begin
        if (svc)
        begin
          if (!st_r.lock)
          begin
            if (key_ok)
            begin
              st_nxt.lock = 1'b1;
              st_nxt.win_sel = st_r.wdata[`SWS_SEL_HI:`SWS_SEL_LO];
              st_nxt.cm_en = st_r.wdata[`SWS_CM_BIT];
              st_nxt.win_cnt = '0;
              st_nxt.lower_act = 1'b1;
            end
            else
            begin
              st_nxt.state = SWS_DRIVE;
            end
          end
          else if (full_match && !early)
          begin
            st_nxt.win_cnt = '0;
            st_nxt.lower_act = 1'b1;
          end
          else
          begin
            st_nxt.state = SWS_DRIVE;
          end
        end
        else if (halt_exit && !(rc_osc_sel && !startup_delay_sel))
        begin
          st_nxt.win_cnt = '0;
          st_nxt.lower_act = 1'b1;
        end
        else if (idle_exit)
        begin
          st_nxt.win_cnt = '0;
          st_nxt.lower_act = 1'b1;
        end
        else if (st_r.tc && !susp)
        begin
          // count only outside halt and idle, so halt resumes with rc_osc_sel set and startup_delay_sel clear
          if (st_r.win_cnt >= upper_last)
          begin
            st_nxt.state = SWS_DRIVE;
          end
          else
          begin
            st_nxt.win_cnt = st_r.win_cnt + 1'b1;
          end
        end
      end
      SWS_DRIVE:
      begin
        // wait until the pin is sensed low
        st_nxt.str_cnt = '0;
        if (!st_r.pin_s2)
        begin
          st_nxt.state = SWS_HOLD;
        end
      end
      SWS_HOLD:
      begin
        if (st_r.tc)
        begin
          if (st_r.str_cnt == STR_LAST)
          begin
            st_nxt.state = SWS_WAIT;
          end
          else
          begin
            st_nxt.str_cnt = st_r.str_cnt + 1'b1;
          end
        end
      end
      SWS_WAIT:
      begin
        if (st_r.pin_s2)
        begin
          st_nxt.state = SWS_RUN;
          st_nxt.win_cnt = '0;
          st_nxt.lower_act = st_r.lock;
        end
      end
      default:
      begin
        st_nxt.state = SWS_RUN;
      end
    endcase

    // one open-drain driver for both fault sources
    st_nxt.fault_oe = (st_nxt.state == SWS_DRIVE)
      | (st_nxt.state == SWS_HOLD) | st_nxt.cm_drive;
    st_nxt.fault_n = 1'b0;

    // write address and data taken in either order
    if (awvalid && st_r.awready)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && st_r.wready)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = wdata[7:0];
      st_nxt.wstrb0 = wstrb[0];
    end
    if (wr_fire)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      if ((st_r.aw_addr == `SWS_OFF_SERVICE)
          || (st_r.aw_addr == `SWS_OFF_STATUS))
      begin
        st_nxt.bresp = RESP_OKAY;
      end
      else
      begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    if (st_r.bvalid && bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = ~st_nxt.aw_have & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_have & ~st_nxt.bvalid;

    // read channel, key field always reads zero
    if (arvalid && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      if (araddr == `SWS_OFF_SERVICE)
      begin
        st_nxt.rdata = {st_r.win_sel, 5'h00, st_r.cm_en};
      end
      else if (araddr == `SWS_OFF_STATUS)
      begin
        st_nxt.rdata = {3'h0, st_r.pin_s2, st_r.cm_drive, st_r.lock,
          st_r.fault_oe, st_r.idle_pend};
      end
      else
      begin
        st_nxt.rdata = 8'h00;
        st_nxt.rresp = RESP_SLVERR;
      end
    end
    if (st_r.rvalid && rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = ~st_nxt.rvalid;
  end

  // ----------------------------------------------------------------------
  // state register; idle counter keeps its value through reset
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.state <= SWS_RUN;
      st_r.win_sel <= `SWS_RST_WIN_SEL;
      st_r.cm_en <= `SWS_RST_CM_EN;
      st_r.fault_n <= 1'b0;
      st_r.idle_cnt <= st_nxt.idle_cnt;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = {24'h00_0000, st_r.rdata};
  assign rresp = st_r.rresp;
  assign fault_out_n = st_r.fault_n;
  assign fault_out_oe = st_r.fault_oe;
  assign idle_tick_pending = st_r.idle_pend;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_EARLY_FAULT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.state == SWS_RUN) && svc && st_r.lock && early
    |=> (st_r.state == SWS_DRIVE) ##1 fault_out_oe)
    else $error("early service did not fault");

  AST_LATE_FAULT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.state == SWS_RUN) && st_r.tc && !susp && !svc && !halt_exit
    && !idle_exit && (st_r.win_cnt == upper_last)
    |=> (st_r.state == SWS_DRIVE))
    else $error("window expiry did not fault");

  AST_KEY_FAULT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.state == SWS_RUN) && svc && !key_ok
    |=> (st_r.state == SWS_DRIVE) && !$changed(st_r.lock))
    else $error("bad key accepted");

  AST_CM_OFF: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !st_r.cm_en && !$past(st_r.cm_en) |-> !st_r.cm_drive)
    else $error("disabled clock monitor drives");

  AST_LOCKED: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_r.lock |=> $stable(st_r.win_sel) && $stable(st_r.cm_en))
    else $error("locked choice changed");

  AST_IGNORE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    svc && ((st_r.state == SWS_DRIVE) || (st_r.state == SWS_HOLD))
    |=> (st_r.state != SWS_RUN) && $stable(st_r.win_cnt)
    && $stable(st_r.lock))
    else $error("service during fault not ignored");

  AST_STRETCH: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.state == SWS_DRIVE) && !st_r.pin_s2 |=> fault_out_oe [*8])
    else $error("fault pin released too soon");

  AST_READ_KEY: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rvalid && $rose(rvalid) && $past(araddr) == `SWS_OFF_SERVICE
    |-> rdata[`SWS_KEY_HI:`SWS_KEY_LO] == 5'h00)
    else $error("key field readable");

  AST_SUSPEND: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.state == SWS_RUN) && susp && !svc && !halt_exit && !idle_exit
    |=> $stable(st_r.win_cnt))
    else $error("window counted while suspended");

  AST_IDLE_EXIT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.state == SWS_RUN) && idle_exit && !svc && !halt_exit
    |=> (st_r.win_cnt == '0) && st_r.lower_act)
    else $error("idle exit did not restart window");

  AST_WIRED: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_r.cm_drive || (st_r.state == SWS_HOLD) |-> fault_out_oe)
    else $error("fault source not on pin");

endmodule
`default_nettype wire

// File: verif/sws_fault_wire.sv
`timescale 1ns/1ps
`default_nettype none

// --------
// pulled-up fault wire, fast or slow rc rise
// --------
module sws_fault_wire #(
  parameter int RISE_CYC = 3
) (
  // clock
  input wire logic aclk,
  // device drive and rise speed
  input wire logic fault_out_n,
  input wire logic fault_out_oe,
  input wire logic slow_rise,
  // sensed wire level
  output logic fault_pin
);
  int rise_cnt = 1000;

  // cycles since the device let go of the wire
  always @(posedge aclk)
    if (fault_out_oe)
      rise_cnt <= 0;
    else
      rise_cnt <= rise_cnt + 1;

  // low while driven, high only once the pull-up has charged it
  assign fault_pin = (fault_out_oe && !fault_out_n) ? 1'b0 :
    (rise_cnt >= (slow_rise ? 4 * RISE_CYC : RISE_CYC));
endmodule

`default_nettype wire

// File: verif/sws_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sws_params.svh"

module sws_supervisor_tb_top;
  // bench state and design inputs, valued at time zero
  logic aclk = 1'b0, aresetn = 1'b0, clock_input_pin = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [`SWS_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rd_d;
  logic halt_mode = 1'b0, idle_mode = 1'b0;
  logic rc_osc_sel = 1'b0, startup_delay_sel = 1'b0;
  logic bready = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] awprot = '0, arprot = '0;
  logic ck_run = 1'b1, oe_seen = 1'b0, slow_rise = 1'b0;
  logic [1:0] ck_div = '0, rd_r, wr_r;
  int cyc = 0, num_errors = 0, cmp_count = 0;
  // design outputs
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic fault_pin, fault_out_n, fault_out_oe, idle_tick_pending;

  // --------
  // supervisor with short counts, one aclk per instruction cycle
  // --------
  sws_supervisor #(
    .TC_DIV(1),
    .LOWER_TC(16),
    .UPPER_BASE_TC(64),
    .CKMON_CYC(200)
  ) i_sws_supervisor (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
    .rready, .rdata, .rresp, .halt_mode, .idle_mode, .rc_osc_sel,
    .startup_delay_sel, .clock_input_pin, .fault_pin, .fault_out_n,
    .fault_out_oe, .idle_tick_pending
  );

  // reset circuit on the far side of the fault pin
  sws_fault_wire i_sws_fault_wire (
    .aclk, .fault_out_n, .fault_out_oe, .slow_rise, .fault_pin
  );

  // free-running aclk
  initial
  begin
    forever #25 aclk = ~aclk;
  end

  // monitored clock, cycle count, sticky fault flag, run limit
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    ck_div <= ck_div + 2'h1;
    if (ck_run && ck_div == 2'h0)
      clock_input_pin <= ~clock_input_pin;
    if (fault_out_oe === 1'b1)
      oe_seen <= 1'b1;
    if (cyc == 30000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  // --------
  // helpers
  // --------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int g);
    cmp_count++;
    if (g < lo || g > hi)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    idle(3);
    aresetn <= 1'b1;
    idle(2);
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit aw_ok = 0;
    bit w_ok = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        aw_ok = 1;
      if (wready === 1'b1)
        w_ok = 1;
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    wr_r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_oe(input logic lvl);
    while (fault_out_oe !== lvl) @(posedge aclk);
  endtask

  // one fault: rise time, hold after the wire is low, then restart
  task automatic fault_cycle(input int lo, input int hi, input bit ign);
    int t0 = cyc;
    wait_oe(1'b1);
    chk_rng("fault rise", lo, hi, cyc - t0);
    t0 = cyc;
    if (ign)
      wr(8'h00, 8'h1b);
    wait_oe(1'b0);
    chk_rng("fault hold", 18, 38, cyc - t0);
    idle(8);
  endtask

  // --------
  // scenarios
  // --------
  task automatic s_regs();
    do_reset();
    rd(8'h00);
    chk("service reset", 32'h0000_00c1, rd_d);
    rd(8'h04);
    chk("lock reset", 32'h0, rd_d & 32'h0000_0006);
    rd(8'h08);
    chk("unmapped rresp", 32'h2, {30'h0, rd_r});
    wr(8'h08, 8'h19);
    chk("unmapped bresp", 32'h2, {30'h0, wr_r});
    // byte lane 0 off: the service register must not see the write
    oe_seen = 0;
    wstrb <= 4'h0;
    wr(8'h00, 8'h1b);
    wstrb <= 4'hf;
    idle(6);
    chk("masked write", 32'h0, 32'(oe_seen));
    wr(8'h00, 8'h1b);
    fault_cycle(0, 6, 1'b0);
    rd(8'h00);
    chk("service unlocked", 32'h0000_00c1, rd_d);
  endtask

  // every window code: first write early, then upper expiry, then early
  task automatic s_sel();
    int lim;
    logic [7:0] v;
    for (int s = 0; s < 4; s++)
    begin
      lim = 64 << s;
      v = {s[1:0], `SWS_KEY_VALUE, s[0]};
      do_reset();
      oe_seen = 0;
      wr(8'h00, v);
      rd(8'h00);
      chk("service locked", {24'h00_0000, v & 8'hc1}, rd_d);
      chk("first early", 32'h0, 32'(oe_seen));
      fault_cycle(lim - 6, lim + 6, 1'b0);
      wr(8'h00, v);
      fault_cycle(0, 6, 1'b0);
    end
  endtask

  // each field wrong in turn, a write ignored while the pin is held
  task automatic s_mismatch();
    logic [7:0] bad [3] = '{8'h02, 8'h40, 8'h01};
    do_reset();
    wr(8'h00, 8'h19);
    for (int i = 0; i < 3; i++)
    begin
      idle(30);
      slow_rise <= (i == 2);
      wr(8'h00, 8'h19 ^ bad[i]);
      fault_cycle(0, 6, i == 0);
    end
    idle(30);
    oe_seen = 0;
    wr(8'h00, 8'h19);
    idle(40);
    chk("good service", 32'h0, 32'(oe_seen));
  endtask

  task automatic s_power();
    int t0;
    rc_osc_sel <= 1'b1;
    startup_delay_sel <= 1'b1;
    halt_mode <= 1'b1;
    ck_run <= 1'b0;
    t0 = cyc;
    wait_oe(1'b1);
    chk_rng("clock fault", 196, 212, cyc - t0);
    idle(100);
    chk("clock held", 32'h1, 32'(fault_out_oe));
    ck_run <= 1'b1;
    t0 = cyc;
    wait_oe(1'b0);
    chk_rng("clock release", 16, 40, cyc - t0);
    oe_seen = 0;
    idle(20);
    halt_mode <= 1'b0;
    idle(50);
    chk("halt restart", 32'h0, 32'(oe_seen));
    wr(8'h00, 8'h19);
    startup_delay_sel <= 1'b0;
    idle(40);
    halt_mode <= 1'b1;
    idle(50);
    halt_mode <= 1'b0;
    t0 = cyc;
    wait_oe(1'b1);
    chk_rng("halt resume", 16, 32, cyc - t0);
    fault_cycle(0, 2, 1'b0);
    idle(30);
    wr(8'h00, 8'h19);
    idle(30);
    idle_mode <= 1'b1;
    idle(100);
    idle_mode <= 1'b0;
    idle(2);
    wr(8'h00, 8'h19);
    fault_cycle(0, 6, 1'b0);
    // crystal option: halt exit restarts a full window
    idle(30);
    rc_osc_sel <= 1'b0;
    wr(8'h00, 8'h19);
    idle(40);
    halt_mode <= 1'b1;
    idle(20);
    halt_mode <= 1'b0;
    oe_seen = 0;
    idle(50);
    chk("crystal restart", 32'h0, 32'(oe_seen));
  endtask

  task automatic s_pending();
    int t0;
    idle_mode <= 1'b1;
    wr(8'h04, 8'h01);
    rd(8'h04);
    chk("pending cleared", 32'h0, rd_d & 32'h1);
    while (idle_tick_pending !== 1'b1) @(posedge aclk);
    t0 = cyc;
    wr(8'h04, 8'h01);
    chk("pending port", 32'h0, 32'(idle_tick_pending));
    while (idle_tick_pending !== 1'b1) @(posedge aclk);
    chk_rng("pending period", 4090, 4100, cyc - t0);
  endtask

  // main sequence
  initial
  begin
    s_regs();
    s_sel();
    s_mismatch();
    s_power();
    s_pending();
    report_and_stop();
  end
endmodule

`default_nettype wire
